/* core/ocsw_switch_ctrl.sv */
`timescale 1ns/100ps
module ocsw_switch_ctrl #(
    parameter int US_CYCLES = ocsw_pkg::US_CYCLES,
    parameter int MS_US = ocsw_pkg::MS_US
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic drive_req,
    input wire logic over_current,
    input wire ocsw_pkg::ocsw_cfg_type cfg,
    output ocsw_pkg::ocsw_pins_type pins
);

    ocsw_pkg::ocsw_state_type state_reg;
    ocsw_pkg::ocsw_state_type state_next;
    ocsw_pkg::ocsw_pins_type pins_reg;
    logic [10:0] trip_cnt_reg;
    logic [10:0] rec_cnt_reg;
    logic [8:0] flash_cnt_reg;
    logic flash_phase_reg;
    logic [10:0] trip_limit;
    logic [10:0] rec_limit;
    logic trip_hit;
    logic rec_done;
    logic out_on_next;
    logic fault_next;
    logic us_tick;
    logic ms_tick;

    // ************************************************
    // timebase
    // ************************************************
    ocsw_timebase #(
        .US_CYCLES(US_CYCLES),
        .MS_US(MS_US)
    ) u_timebase (
        .clk(clk),
        .sys_rst(sys_rst),
        .us_tick(us_tick),
        .ms_tick(ms_tick)
    );

    // ************************************************
    // limits
    // ************************************************
    always_comb begin
        trip_limit = ocsw_pkg::TRIP_US[cfg.trip_sel]; // RQ12
        if (cfg.recovery_prog) begin
            rec_limit = ocsw_pkg::RECOVERY_MS[cfg.recovery_sel];
        end else if (cfg.long_default) begin
            rec_limit = ocsw_pkg::RECOVERY_DEF_LONG_MS; // RQ11
        end else begin
            rec_limit = ocsw_pkg::RECOVERY_DEF_SHORT_MS; // RQ11
        end
        // short peaks stay below the limit and never trip
        trip_hit = over_current && (trip_cnt_reg >= trip_limit); // RQ4
        rec_done = rec_cnt_reg >= rec_limit;
    end

    // ************************************************
    // state machine
    // ************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ocsw_pkg::ST_IDLE: begin
                if (drive_req) begin
                    state_next = ocsw_pkg::ST_ON; // RQ1 RQ9
                end
            end
            ocsw_pkg::ST_ON: begin
                if (!drive_req) begin
                    state_next = ocsw_pkg::ST_IDLE; // RQ1
                end else if (trip_hit) begin
                    state_next = ocsw_pkg::ST_WAIT; // RQ5
                end
            end
            ocsw_pkg::ST_WAIT: begin
                if (!drive_req) begin
                    state_next = ocsw_pkg::ST_IDLE; // RQ8 RQ9
                end else if (rec_done) begin
                    state_next = ocsw_pkg::ST_RETRY; // RQ6
                end
            end
            ocsw_pkg::ST_RETRY: begin
                if (!drive_req) begin
                    state_next = ocsw_pkg::ST_IDLE;
                end else if (over_current) begin
                    state_next = ocsw_pkg::ST_WAIT; // RQ7
                end else begin
                    state_next = ocsw_pkg::ST_ON; // RQ8
                end
            end
            default: begin
                state_next = ocsw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ocsw_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************
    // trip and recovery counters
    // ************************************************
    // any drop of the request wipes both timers
    always_ff @(posedge clk) begin
        if (sys_rst || !drive_req || !over_current ||
            state_reg != ocsw_pkg::ST_ON) begin
            trip_cnt_reg <= 11'h000; // RQ16
        end else if (us_tick && trip_cnt_reg != ocsw_pkg::CNT_MAX) begin
            trip_cnt_reg <= trip_cnt_reg + 11'h001; // RQ16
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !drive_req || state_reg != ocsw_pkg::ST_WAIT) begin
            rec_cnt_reg <= 11'h000; // RQ16
        end else if (ms_tick && !rec_done) begin
            rec_cnt_reg <= rec_cnt_reg + 11'h001; // RQ6
        end
    end

    // ************************************************
    // fault flasher
    // ************************************************
    // retry states count as fault so the blink keeps its rhythm
    always_comb begin
        out_on_next = (state_next == ocsw_pkg::ST_ON) ||
                      (state_next == ocsw_pkg::ST_RETRY);
        fault_next = (state_next == ocsw_pkg::ST_WAIT) ||
                     (state_next == ocsw_pkg::ST_RETRY);
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !fault_next) begin
            flash_cnt_reg <= 9'h000;
            flash_phase_reg <= 1'b1;
        end else if (ms_tick) begin
            if (flash_cnt_reg == ocsw_pkg::FLASH_HALF_MS - 9'h001) begin
                flash_cnt_reg <= 9'h000;
                flash_phase_reg <= !flash_phase_reg; // RQ13
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 9'h001;
            end
        end
    end

    // ************************************************
    // output pins
    // ************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins_reg <= '0;
        end else begin
            pins_reg.sw_int_on <= out_on_next && cfg.sense_gnd; // RQ2 RQ15
            pins_reg.ext_drive <= out_on_next && !cfg.sense_gnd; // RQ15
            pins_reg.status_o <= 1'b0;
            // open drain: floats unless a fault pulls it low
            pins_reg.status_oe <= fault_next &&
                (!cfg.flash_ind || flash_phase_reg); // RQ3 RQ13
        end
    end

    assign pins = pins_reg;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_low_req_off: assert property ( // RQ1
        !drive_req |=> !pins.sw_int_on && !pins.ext_drive)
        else $error("output on while request low");

    a_high_req_on: assert property ( // RQ2
        (state_reg == ocsw_pkg::ST_IDLE) && drive_req && cfg.sense_gnd
        ##1 cfg.sense_gnd |-> pins.sw_int_on)
        else $error("internal switch not closed on request");

    a_no_fault_float: assert property ( // RQ3
        (state_reg == ocsw_pkg::ST_ON) && (state_next == ocsw_pkg::ST_ON)
        |=> !pins.status_oe)
        else $error("status driven without fault");

    a_short_peak_kept: assert property ( // RQ4
        (state_reg == ocsw_pkg::ST_ON) && drive_req &&
        (trip_cnt_reg < trip_limit) |=> state_reg == ocsw_pkg::ST_ON)
        else $error("trip before delay elapsed");

    a_long_trip_off: assert property ( // RQ5
        (state_reg == ocsw_pkg::ST_ON) && drive_req && over_current &&
        (trip_cnt_reg >= trip_limit)
        |=> (state_reg == ocsw_pkg::ST_WAIT) && !pins.sw_int_on &&
            !pins.ext_drive)
        else $error("sustained over-current did not trip");

    a_wait_holds_off: assert property ( // RQ6
        (state_reg == ocsw_pkg::ST_WAIT) && drive_req && !rec_done
        |=> (state_reg == ocsw_pkg::ST_WAIT) && !pins.sw_int_on &&
            !pins.ext_drive)
        else $error("output left wait early");

    a_retry_fail_off: assert property ( // RQ7
        (state_reg == ocsw_pkg::ST_RETRY) && drive_req && over_current
        |=> (state_reg == ocsw_pkg::ST_WAIT) && (rec_cnt_reg == 11'h000)
        ##1 !pins.sw_int_on && !pins.ext_drive)
        else $error("retry into short not shut off");

    a_retry_ok_on: assert property ( // RQ8
        (state_reg == ocsw_pkg::ST_RETRY) && drive_req && !over_current
        |=> state_reg == ocsw_pkg::ST_ON)
        else $error("clean retry did not resume");

    a_early_restart: assert property ( // RQ9
        (state_reg == ocsw_pkg::ST_WAIT) && !drive_req ##1 drive_req
        |=> (state_reg == ocsw_pkg::ST_ON) &&
            (pins.sw_int_on || pins.ext_drive))
        else $error("request toggle did not restart");

    a_timers_cleared: assert property ( // RQ16
        !drive_req |=> (trip_cnt_reg == 11'h000) &&
        (rec_cnt_reg == 11'h000))
        else $error("timers not cleared on low request");

    a_flash_toggle: assert property ( // RQ13
        fault_next && $past(fault_next) && ms_tick &&
        (flash_cnt_reg == ocsw_pkg::FLASH_HALF_MS - 9'h001)
        |=> flash_phase_reg != $past(flash_phase_reg))
        else $error("flash phase did not toggle");

    a_mode_exclusive: assert property ( // RQ15
        !(pins.sw_int_on && pins.ext_drive))
        else $error("both drivers active");

    c_trip: cover property (
        (state_reg == ocsw_pkg::ST_ON) ##1 (state_reg == ocsw_pkg::ST_WAIT));
    c_retry_ok: cover property (
        (state_reg == ocsw_pkg::ST_RETRY) ##1 (state_reg == ocsw_pkg::ST_ON));
    c_retry_fail: cover property (
        (state_reg == ocsw_pkg::ST_RETRY) ##1 (state_reg == ocsw_pkg::ST_WAIT));
    c_early: cover property (
        (state_reg == ocsw_pkg::ST_WAIT) ##1 (state_reg == ocsw_pkg::ST_IDLE)
        ##1 (state_reg == ocsw_pkg::ST_ON));

endmodule : ocsw_switch_ctrl

/* common/ocsw_pkg.sv */
// Contract
// RQ1: With no over-current the output follows the drive request level.
// RQ2: A high drive request closes the switch toward the supply rail.
// RQ3: Below the trip threshold the output stays on and status floats.
// RQ4: Over-current shorter than the trip delay is ignored.
// RQ5: Over-current lasting past the trip delay turns the output off.
// RQ6: After a trip the output stays off for the recovery wait, then retries.
// RQ7: A retry into a standing short turns the output off again at once.
// RQ8: Trip, wait and retry repeat until the fault clears or request drops.
// RQ9: Dropping and raising the request ends a recovery wait at once.
// RQ10: The configuring party keeps recovery wait at least 1000 trip delays.
// RQ11: After power-on the recovery wait is the default, 500 ms or 20 ms.
// RQ12: The trip delay is chosen from eight values up to 1000 us.
// RQ13: The flashing variant toggles status at 1.7 Hz, 50% duty, on fault.
// RQ14: The controller holds the request low through power-up.
// RQ15: Sense tied low uses the internal switch, else the external driver.
// RQ16: Trip and recovery counters run on a timebase, cleared on low request.
package ocsw_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    localparam int FLASH_MILLIHZ = 1700;
    localparam int FLASH_HALF_MS_INT = (1000 * 1000) / (2 * FLASH_MILLIHZ);
    localparam logic [8:0] FLASH_HALF_MS = 9'(FLASH_HALF_MS_INT);
    localparam logic [10:0] CNT_MAX = 11'h7FF;

    // trip delay choices in microseconds
    localparam logic [10:0] TRIP_US [0:7] = '{
        11'h005, 11'h00A, 11'h014, 11'h032,
        11'h064, 11'h0C8, 11'h1F4, 11'h3E8
    };

    // recovery wait choices in milliseconds
    localparam logic [10:0] RECOVERY_MS [0:7] = '{
        11'h00A, 11'h014, 11'h032, 11'h064,
        11'h0C8, 11'h1F4, 11'h3E8, 11'h5DC
    };

    localparam logic [10:0] RECOVERY_DEF_LONG_MS = 11'h1F4;
    localparam logic [10:0] RECOVERY_DEF_SHORT_MS = 11'h014;

    // ************************************************
    // types
    // ************************************************
    typedef struct packed {
        logic [2:0] trip_sel;
        logic [2:0] recovery_sel;
        logic recovery_prog;
        logic long_default;
        logic flash_ind;
        logic sense_gnd;
    } ocsw_cfg_type;

    typedef struct packed {
        logic sw_int_on;
        logic ext_drive;
        logic status_o;
        logic status_oe;
    } ocsw_pins_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_WAIT,
        ST_RETRY
    } ocsw_state_type;

endpackage : ocsw_pkg

/* core/ocsw_timebase.sv */
`timescale 1ns/100ps
module ocsw_timebase #(
    parameter int US_CYCLES = ocsw_pkg::US_CYCLES,
    parameter int MS_US = ocsw_pkg::MS_US
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic us_tick,
    output logic ms_tick
);

    logic [11:0] cyc_reg;
    logic [11:0] us_reg;
    logic us_tick_reg;
    logic ms_tick_reg;

    // ************************************************
    // microsecond prescaler
    // ************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cyc_reg <= 12'h000;
            us_tick_reg <= 1'b0;
        end else if (cyc_reg == 12'(US_CYCLES - 1)) begin
            cyc_reg <= 12'h000;
            us_tick_reg <= 1'b1;
        end else begin
            cyc_reg <= cyc_reg + 12'h001;
            us_tick_reg <= 1'b0;
        end
    end

    // ************************************************
    // millisecond prescaler
    // ************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            us_reg <= 12'h000;
            ms_tick_reg <= 1'b0;
        end else if (us_tick_reg && us_reg == 12'(MS_US - 1)) begin
            us_reg <= 12'h000;
            ms_tick_reg <= 1'b1;
        end else begin
            if (us_tick_reg) begin
                us_reg <= us_reg + 12'h001;
            end
            ms_tick_reg <= 1'b0;
        end
    end

    assign us_tick = us_tick_reg;
    assign ms_tick = ms_tick_reg;

endmodule : ocsw_timebase

/* verification/ocsw_load_model.sv */
`timescale 1ns/100ps
module ocsw_load_model (
    input wire logic sense_gnd,
    input wire logic short_en,
    input wire ocsw_pkg::ocsw_pins_type pins,
    output logic over_current,
    output logic status_line,
    output logic out_on
);
    // ************************************************
    // load and status line
    // ************************************************
    // the comparator only sees current while a switch path conducts
    always_comb begin
        out_on = sense_gnd ? pins.sw_int_on : pins.ext_drive;
        over_current = short_en & out_on;
    end

    // open drain: host pull-up wins whenever the pin floats
    always_comb begin
        status_line = pins.status_oe ? pins.status_o : 1'b1;
    end
endmodule : ocsw_load_model

/* verification/tb_ocsw_switch_ctrl.sv */
`timescale 1ns/100ps
module tb_ocsw_switch_ctrl;
    localparam int UC = 2;
    localparam int MU = 4;
    localparam int MS = UC * MU;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic drive_req = 1'b0;
    logic short_en = 1'b0;
    logic over_current;
    logic status_line;
    logic out_on;
    ocsw_pkg::ocsw_cfg_type cfg = '0;
    ocsw_pkg::ocsw_pins_type pins;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    int t;
    int r;
    int trip_us [8] = '{5, 10, 20, 50, 100, 200, 500, 1000};
    // model queue: predicted {sw_int_on, ext_drive, status_line}
    logic [2:0] mdl_q[$];

    ocsw_switch_ctrl #(.US_CYCLES(UC), .MS_US(MU)) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .drive_req(drive_req),
        .over_current(over_current),
        .cfg(cfg),
        .pins(pins)
    );

    ocsw_load_model u_load (
        .sense_gnd(cfg.sense_gnd),
        .short_en(short_en),
        .pins(pins),
        .over_current(over_current),
        .status_line(status_line),
        .out_on(out_on)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // ************************************************
    // checking helpers
    // ************************************************
    task automatic check_bit(string name, logic exp, logic seen);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : check_bit

    task automatic check_span(string name, int lo, int hi, int seen);
        checks++;
        if (seen < lo || seen > hi) begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                name, lo, hi, seen);
        end
    endtask : check_span

    // ************************************************
    // reference model
    // ************************************************
    // no over-current: output follows request, status floats high
    task automatic mdl_push(logic req, logic gnd);
        mdl_q.push_back({req & gnd, req & ~gnd, 1'b1});
    endtask : mdl_push

    task automatic check_track();
        logic [2:0] e;
        e = mdl_q.pop_front();
        check_bit("sw_int_on", e[2], pins.sw_int_on);
        check_bit("ext_drive", e[1], pins.ext_drive);
        check_bit("status_line", e[0], status_line);
    endtask : check_track

    task automatic cycle(int k);
        repeat (k) @(negedge clk);
    endtask : cycle

    // counts falling edges until the output reaches the wanted level
    task automatic wait_out(logic exp, int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (out_on !== exp && cnt < lim);
    endtask : wait_out

    task automatic trip_now();
        short_en = 1'b1;
        wait_out(1'b0, UC * 1000 + 20, n);
    endtask : trip_now

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // runaway guard well above the planned run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            wrap_up();
        end
    end

    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        void'($urandom(95445));
        cycle(4);
        sys_rst = 1'b0;
        for (int i = 0; i < 40; i++) begin
            drive_req = 1'($urandom_range(0, 1));
            cfg.sense_gnd = 1'($urandom_range(0, 1));
            mdl_push(drive_req, cfg.sense_gnd);
            cycle(2);
            check_track();
        end
        // long recovery keeps the ratio safe for every trip choice
        cfg = '0;
        cfg.sense_gnd = 1'b1;
        cfg.recovery_prog = 1'b1;
        cfg.recovery_sel = 3'h7;
        drive_req = 1'b1;
        cycle(3);
        for (int k = 0; k < 4; k++) begin
            short_en = 1'b1;
            cycle($urandom_range(1, UC * 5 - 3));
            short_en = 1'b0;
            mdl_push(1'b1, 1'b1);
            cycle(2);
            check_track();
            check_bit("peak_out", 1'b1, out_on);
        end
        for (int s = 0; s < 8; s++) begin
            cfg.trip_sel = 3'(s);
            t = UC * trip_us[s];
            drive_req = 1'b1;
            cycle(3);
            trip_now();
            check_span("trip_cycles", t - 2, t + UC + 3, n);
            cycle(1);
            check_bit("trip_status", 1'b0, status_line);
            drive_req = 1'b0;
            short_en = 1'b0;
            cycle(3);
            check_bit("idle_status", 1'b1, status_line);
        end
        // programmed 10 ms wait, retried into a standing short twice
        cfg.trip_sel = 3'h0;
        cfg.recovery_sel = 3'h0;
        drive_req = 1'b1;
        trip_now();
        for (int k = 0; k < 2; k++) begin
            wait_out(1'b1, 20 * MS, n);
            check_span("recovery_cycles", 10 * MS - MS,
                10 * MS + MS + 2, n);
            wait_out(1'b0, 5, n);
            check_span("retry_cycles", 1, 2, n);
        end
        short_en = 1'b0;
        wait_out(1'b1, 20 * MS, n);
        mdl_push(1'b1, 1'b1);
        cycle(20);
        check_track();
        check_bit("healed_out", 1'b1, out_on);
        for (int d = 0; d < 2; d++) begin
            cfg.recovery_prog = 1'b0;
            cfg.long_default = 1'(d);
            r = (d == 1) ? 500 * MS : 20 * MS;
            trip_now();
            wait_out(1'b1, r + 4 * MS, n);
            check_span("default_wait", r - MS, r + MS + 2, n);
            short_en = 1'b0;
            drive_req = 1'b0;
            cycle(3);
            drive_req = 1'b1;
        end
        // early restart out of a 1500 ms wait
        cfg.recovery_prog = 1'b1;
        cfg.recovery_sel = 3'h7;
        trip_now();
        cycle(5);
        drive_req = 1'b0;
        cycle(1);
        drive_req = 1'b1;
        wait_out(1'b1, 5, n);
        check_span("restart_cycles", 1, 3, n);
        wait_out(1'b0, UC * 10, n);
        check_span("restart_trip", UC * 5 - 2, UC * 5 + UC + 3, n);
        drive_req = 1'b0;
        short_en = 1'b0;
        cycle(3);
        cfg.flash_ind = 1'b1;
        drive_req = 1'b1;
        cycle(3);
        trip_now();
        cycle(1);
        check_bit("flash_low", 1'b0, status_line);
        n = 0;
        while (status_line !== 1'b1 && n < 3000) begin
            cycle(1);
            n++;
        end
        check_span("flash_half", 294 * MS - 2 * MS,
            294 * MS + 2 * MS, n);
        drive_req = 1'b0;
        short_en = 1'b0;
        cycle(3);
        wrap_up();
    end
endmodule : tb_ocsw_switch_ctrl
